/* File: src/schp_host_port.sv */
`timescale 1ns/10ps
// Operation
// - channel and control/data selects latched when strobe meets chip enable
// - data bus driven while chip enable and read strobe are low outside acknowledge, or during a won acknowledge read
// - data-select accesses leave the register pointer untouched
// - control-select accesses clear the pointer after the internal access
// - acknowledge input sampled on every rising clock edge
// - during acknowledge, channel, control/data and write strobe are ignored
// - read strobe in acknowledge with pending and chain in sets in-service, drives vector
// - interrupt request drops on the same read edge that sets in-service
// - pending bits update at half clock rate, halted while pointer selects 2 or 3
// - one shared pointer, loaded by a command write on either channel
// - next control access reaches selected register, then pointer returns to zero
// - data-select accesses reach receive/transmit buffers regardless of pointer
// - pointer in command bits 2..0 selects 0..7, command may accompany it
// - high bank 8..15 needs point-high command with the pointer bits
// - point-high is 001 in bits 5..3; shadow reads follow the standard map
// - channel chosen at the register access, A high; regs 2 and 9 shared
// - external control bit 2 enables frame FIFO and read registers 6 and 7
// - external control bit 0 enables alternate option register writes
// - strobes ignored until chip enable is active, except the read strobe during acknowledge
module schp_host_port (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic chan_sel,
    input wire logic dc_sel,
    input wire logic interrupt_ack_n,
    input wire logic chain_enable_in,
    input wire logic [schp_pkg::DATA_W-1:0] data_in,
    output logic [schp_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    output logic int_n,
    output logic chain_enable_out,
    output logic acc_wr,
    output logic acc_rd,
    output logic acc_chan_a,
    output logic acc_shared,
    output logic acc_alt,
    output logic acc_wreg_read,
    output logic [schp_pkg::IDX_W-1:0] acc_index,
    output logic [schp_pkg::DATA_W-1:0] acc_wdata,
    input wire logic [schp_pkg::DATA_W-1:0] acc_rdata,
    input wire logic [schp_pkg::IP_W-1:0] pend_src,
    input wire logic ius_clear,
    input wire logic [schp_pkg::DATA_W-1:0] vector_in,
    output logic [schp_pkg::IP_W-1:0] in_service,
    output logic [schp_pkg::IP_W-1:0] pending,
    output logic fifo_en_a,
    output logic fifo_en_b,
    output logic enh_en_a,
    output logic enh_en_b
);
    import schp_pkg::*;

    // pin synchronisers: first stage is read only by second stage
    logic [4:0] ctl_m_r;
    logic [4:0] ctl_s_r;
    logic [1:0] sel_m_r;
    logic [1:0] sel_s_r;
    logic [DATA_W-1:0] din_m_r;
    logic [DATA_W-1:0] din_s_r;
    logic iei_m_r;
    logic iei_s_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_m_r <= 5'h1f;
            ctl_s_r <= 5'h1f;
            sel_m_r <= 2'h0;
            sel_s_r <= 2'h0;
            din_m_r <= DATA_RST;
            din_s_r <= DATA_RST;
            iei_m_r <= 1'b0;
            iei_s_r <= 1'b0;
        end else begin
            ctl_m_r <= {interrupt_ack_n, ce_n, rd_n, wr_n, 1'b1};
            ctl_s_r <= ctl_m_r;
            sel_m_r <= {chan_sel, dc_sel};
            sel_s_r <= sel_m_r;
            din_m_r <= data_in;
            din_s_r <= din_m_r;
            iei_m_r <= chain_enable_in;
            iei_s_r <= iei_m_r;
        end
    end

    wire ack_n_s = ctl_s_r[4];
    wire ce_act = !ctl_s_r[3];
    wire rd_act = !ctl_s_r[2];
    wire wr_act = !ctl_s_r[1];
    wire ack_act = !ack_n_s;

    // access qualifiers; write strobe does not count during acknowledge
    wire rd_q = ce_act && rd_act && !ack_act;
    wire wr_q = ce_act && wr_act && !ack_act;
    wire ack_rd = ack_act && rd_act;
    wire any_q = rd_q || wr_q;

    logic rd_q_r;
    logic wr_q_r;
    logic ack_rd_r;
    wire rd_start = rd_q && !rd_q_r && !wr_q_r;
    wire wr_start = wr_q && !wr_q_r && !rd_q_r;
    wire ack_fall = ack_rd && !ack_rd_r;

    schp_state_t state_r;
    schp_state_t state_nxt;
    logic is_wr_r;
    logic chan_r;
    logic dc_r;
    logic [DATA_W-1:0] wdata_r;
    logic [PTR_W-1:0] ptr_r;
    logic hi_r;
    logic [DATA_W-1:0] dout_r;
    logic [1:0] fifo_en_r;
    logic [1:0] enh_en_r;
    logic [1:0] xrd_en_r;
    logic [IP_W-1:0] ip_r;
    logic [IP_W-1:0] ius_r;
    logic half_r;

    // latched channel index into the per-channel enable pairs
    wire ch = chan_r;
    wire [IDX_W-1:0] ptr_idx = {hi_r, ptr_r};
    // data-select bypasses the pointer straight to the buffers
    wire [IDX_W-1:0] base_idx = dc_r ? IDX_BUF : ptr_idx;

    // read-side index remap for image registers
    function automatic logic [IDX_W:0] rd_map(input logic [IDX_W-1:0] idx,
                                              input logic fifo, input logic xrd);
        logic [IDX_W-1:0] r;
        logic w;
        r = idx;
        w = 1'b0;
        case (idx)
            IDX_WR4, IDX_WR5: begin
                if (xrd) begin
                    w = 1'b1;
                end else begin
                    r = idx - LOW_IMAGE_OFS;
                end
            end
            IDX_RR6, IDX_RR7: begin
                if (!fifo) begin
                    r = idx - LOW_IMAGE_OFS;
                end
            end
            IDX_MIC: begin
                if (xrd) begin
                    r = IDX_WR3;
                    w = 1'b1;
                end else begin
                    r = IDX_BRG_HI;
                end
            end
            IDX_SH11: begin
                if (xrd) begin
                    r = IDX_MISC;
                    w = 1'b1;
                end else begin
                    r = IDX_EXT;
                end
            end
            IDX_SH14: begin
                if (xrd) begin
                    r = IDX_RR7;
                    w = 1'b1;
                end else begin
                    r = IDX_MISC;
                end
            end
            default: begin
                r = idx;
            end
        endcase
        return {w, r};
    endfunction

    wire [IDX_W:0] rd_sel = rd_map(base_idx, fifo_en_r[ch], xrd_en_r[ch]);

    // next state of the access sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SCHP_IDLE: begin
                if (rd_start || wr_start) begin
                    state_nxt = SCHP_DO;
                end
            end
            SCHP_DO: begin
                state_nxt = SCHP_HOLD;
            end
            SCHP_HOLD: begin
                // one access per strobe: wait for release
                if (!any_q) begin
                    state_nxt = SCHP_IDLE;
                end
            end
            default: begin
                state_nxt = SCHP_IDLE;
            end
        endcase
    end

    wire do_acc = state_r == SCHP_DO;
    wire is_cmd_wr = do_acc && is_wr_r && !dc_r && ptr_idx == IDX_CMD;
    wire is_ext_wr = do_acc && is_wr_r && !dc_r && ptr_idx == IDX_EXT;
    wire is_alt_wr = do_acc && is_wr_r && !dc_r && ptr_idx == IDX_RR7 &&
                     enh_en_r[ch];
    wire [CMD_W-1:0] cmd_field = wdata_r[CMD_LSB +: CMD_W];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SCHP_IDLE;
            rd_q_r <= 1'b0;
            wr_q_r <= 1'b0;
            ack_rd_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            rd_q_r <= rd_q;
            wr_q_r <= wr_q;
            ack_rd_r <= ack_rd;
        end
    end

    // selects captured once at strobe coincidence and held for the access
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            is_wr_r <= 1'b0;
            chan_r <= 1'b0;
            dc_r <= 1'b0;
            wdata_r <= DATA_RST;
        end else if (state_r == SCHP_IDLE && (rd_start || wr_start)) begin
            is_wr_r <= wr_start;
            chan_r <= sel_s_r[1];
            dc_r <= sel_s_r[0];
            wdata_r <= din_s_r;
        end
    end

    // shared pointer: any channel loads it, control accesses clear it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr_r <= PTR_RST[PTR_W-1:0];
            hi_r <= 1'b0;
        end else if (is_cmd_wr) begin
            ptr_r <= wdata_r[PTR_LSB +: PTR_W];
            hi_r <= cmd_field == CMD_POINT_HIGH;
        end else if (do_acc && !dc_r) begin
            ptr_r <= PTR_RST[PTR_W-1:0];
            hi_r <= 1'b0;
        end
    end

    // enhancement enables, kept per channel
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fifo_en_r <= 2'h0;
            enh_en_r <= 2'h0;
            xrd_en_r <= 2'h0;
        end else begin
            if (is_ext_wr) begin
                fifo_en_r[ch] <= wdata_r[EXT_FIFO_BIT];
                enh_en_r[ch] <= wdata_r[EXT_ENH_BIT];
                if (!wdata_r[EXT_ENH_BIT]) begin
                    xrd_en_r[ch] <= 1'b0;
                end
            end
            if (is_alt_wr) begin
                xrd_en_r[ch] <= wdata_r[ALT_XRD_BIT];
            end
        end
    end

    wire grant = ack_fall && iei_s_r && |ip_r;
    // read data and vector output register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dout_r <= DATA_RST;
        end else if (grant) begin
            dout_r <= vector_in;
        end else if (do_acc && !is_wr_r) begin
            dout_r <= acc_rdata;
        end
    end

    // pending bits on a half-rate tick, frozen while pointer sits on 2 or 3
    wire ptr_on_irq = !hi_r && (ptr_idx == IDX_VEC || ptr_idx == IDX_PEND);
    wire ip_tick = half_r && !ptr_on_irq;
    wire [IP_W-1:0] ip_open = ip_r & ~ius_r;
    wire irq_want = |ip_open && !(|ius_r);

    // highest numbered pending source wins
    function automatic logic [IP_W-1:0] top_bit(input logic [IP_W-1:0] v);
        logic [IP_W-1:0] o;
        o = '0;
        for (int i = 0; i < IP_W; i++) begin
            if (v[i]) begin
                o = '0;
                o[i] = 1'b1;
            end
        end
        return o;
    endfunction

    wire [IP_W-1:0] grant_bit = top_bit(ip_r);
    wire [IP_W-1:0] clear_bit = top_bit(ius_r);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_r <= 1'b0;
            ip_r <= IP_RST;
            ius_r <= IP_RST;
        end else begin
            half_r <= !half_r;
            if (ip_tick) begin
                ip_r <= pend_src;
            end
            // a grant in the same cycle as a clear keeps its latch
            if (grant) begin
                ius_r <= (ius_r & ~(ius_clear ? clear_bit : IP_RST)) | grant_bit;
            end else if (ius_clear) begin
                ius_r <= ius_r & ~clear_bit;
            end
        end
    end

    // request drops combinationally on the grant edge so no extra cycle shows
    assign int_n = !(irq_want && !grant);
    assign chain_enable_out = iei_s_r && !(|ius_r) && !(ack_act && |ip_r);

    // vector drive only for the acknowledge read we won, so a neighbour's vector is not fought
    logic vec_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vec_r <= 1'b0;
        end else begin
            vec_r <= grant || (vec_r && ack_rd);
        end
    end
    // bus drivers follow chip enable and read strobe outside acknowledge, or the acknowledge read after a grant
    wire drive = (ce_act && rd_act && !ack_act) || (ack_rd && vec_r);
    assign data_oe_n = !drive;
    assign data_out = dout_r;

    assign acc_wr = do_acc && is_wr_r;
    assign acc_rd = do_acc && !is_wr_r;
    assign acc_chan_a = chan_r;
    assign acc_index = is_wr_r ? base_idx : rd_sel[IDX_W-1:0];
    assign acc_wreg_read = !is_wr_r && rd_sel[IDX_W];
    assign acc_shared = is_wr_r && (base_idx == IDX_VEC || base_idx == IDX_MIC);
    assign acc_alt = is_alt_wr;
    assign acc_wdata = wdata_r;
    assign in_service = ius_r;
    assign pending = ip_r;
    assign fifo_en_a = fifo_en_r[1];
    assign fifo_en_b = fifo_en_r[0];
    assign enh_en_a = enh_en_r[1];
    assign enh_en_b = enh_en_r[0];
endmodule

/* File: src/schp_pkg.sv */
package schp_pkg;
    // pointer field of the command register
    localparam int PTR_LSB = 0;
    localparam int PTR_W = 3;
    localparam int CMD_LSB = 3;
    localparam int CMD_W = 3;
    localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
    localparam int IDX_W = 4;
    localparam int DATA_W = 8;
    // register indices
    localparam logic [3:0] IDX_CMD = 4'h0;
    localparam logic [3:0] IDX_VEC = 4'h2;
    localparam logic [3:0] IDX_PEND = 4'h3;
    localparam logic [3:0] IDX_WR4 = 4'h4;
    localparam logic [3:0] IDX_WR5 = 4'h5;
    localparam logic [3:0] IDX_RR6 = 4'h6;
    localparam logic [3:0] IDX_RR7 = 4'h7;
    localparam logic [3:0] IDX_BUF = 4'h8;
    localparam logic [3:0] IDX_MIC = 4'h9;
    localparam logic [3:0] IDX_MISC = 4'ha;
    localparam logic [3:0] IDX_SH11 = 4'hb;
    localparam logic [3:0] IDX_BRG_HI = 4'hd;
    localparam logic [3:0] IDX_SH14 = 4'he;
    localparam logic [3:0] IDX_EXT = 4'hf;
    localparam logic [3:0] IDX_WR3 = 4'h3;
    // image offset applied to low-bank shadow reads 4..7
    localparam logic [3:0] LOW_IMAGE_OFS = 4'h4;
    // enable bits
    localparam int EXT_FIFO_BIT = 2;
    localparam int EXT_ENH_BIT = 0;
    localparam int ALT_XRD_BIT = 6;
    // interrupt sources
    localparam int IP_W = 6;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] PTR_RST = 4'h0;
    localparam logic [5:0] IP_RST = 6'h00;
    typedef enum logic [1:0] {SCHP_IDLE, SCHP_DO, SCHP_HOLD} schp_state_t;
endpackage

/* File: tb/schp_host_model.sv */
`timescale 1ns/10ps
module schp_host_model (
    input wire logic clk,
    output logic ce_n,
    output logic rd_n,
    output logic wr_n,
    output logic chan_sel,
    output logic dc_sel,
    output logic interrupt_ack_n,
    output logic [schp_pkg::DATA_W-1:0] data_in
);
    import schp_pkg::*;
    initial begin
        {ce_n, rd_n, wr_n, interrupt_ack_n} = 4'hf;
        {chan_sel, dc_sel} = 2'h0;
        data_in = 8'h00;
    end
    task automatic access(input logic ce, input logic w, input logic ch, input logic dc,
        input logic [DATA_W-1:0] d);
        @(posedge clk) #1;
        {chan_sel, dc_sel, data_in} = {ch, dc, d};
        {ce_n, wr_n, rd_n} = {!ce, !w, w};
        repeat (6) @(posedge clk);
        #1 {ce_n, rd_n, wr_n} = 3'h7;
        // released bus must not look like the last value
        data_in = ~d;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic ack_cycle();
        @(posedge clk) #1 interrupt_ack_n = 1'b0;
        // chip enable and write strobe under acknowledge must both be ignored
        {ce_n, wr_n, chan_sel, dc_sel} = {1'b0, 1'b0, ~chan_sel, ~dc_sel};
        repeat (3) @(posedge clk);
        #1 rd_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 {ce_n, rd_n, wr_n} = 3'h7;
        // acknowledge released last so a stale write strobe is never seen
        repeat (3) @(posedge clk);
        #1 interrupt_ack_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule

/* File: tb/schp_host_port_tb_top.sv */
`timescale 1ns/10ps
module schp_host_port_tb_top;
    import schp_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic chain_enable_in = 1'b0;
    logic ius_clear = 1'b0;
    logic [IP_W-1:0] pend_src = '0;
    logic [DATA_W-1:0] vector_in = 8'h5a;
    logic ce_n, rd_n, wr_n, chan_sel, dc_sel, interrupt_ack_n;
    logic [DATA_W-1:0] data_in, data_out, acc_wdata, acc_rdata, last_wd;
    logic data_oe_n, int_n, chain_enable_out, acc_wr, acc_rd, acc_chan_a, acc_shared;
    logic acc_alt, acc_wreg_read, fifo_en_a, fifo_en_b, enh_en_a, enh_en_b;
    logic last_ch, last_sh, last_alt, last_wr;
    logic [IDX_W-1:0] acc_index, last_idx;
    logic [IP_W-1:0] in_service, pending;
    int failures = 0;
    int total_checks = 0;
    int n_acc = 0;
    int n0;
    // {write, chan_a, data_sel, alt on a write or write-register image on a read} nibble,
    // data byte, expected index
    logic [15:0] rows [0:38] = '{16'hc050, 16'h0001, 16'h4000, 16'h80b0, 16'h6008,
        16'h400f, 16'hc0e0, 16'h8aae, 16'hc090, 16'h000d, 16'hc0a0, 16'h400a, 16'he5c8,
        16'h8020, 16'hc772, 16'hc1b0, 16'h4003, 16'hc0f0, 16'hc04f, 16'hc060, 16'h4006,
        16'h80f0, 16'h801f, 16'h8070, 16'h9337, 16'hc090, 16'h8119, 16'h8070, 16'h9407,
        16'h8090, 16'h1003, 16'h8040, 16'h1004, 16'h80e0, 16'h1007, 16'hc0e0, 16'h400a,
        16'h8060, 16'h0002};
    always #2.5 clk = ~clk;
    assign acc_rdata = {acc_chan_a, 3'h0, acc_index};
    always @(posedge clk) begin
        if (acc_wr || acc_rd) begin
            n_acc <= n_acc + 1;
            {last_idx, last_ch, last_wd, last_alt, last_sh, last_wr} <=
                {acc_index, acc_chan_a, acc_wdata, acc_alt, acc_shared, acc_wreg_read};
        end
    end
    schp_host_port u_dut (.clk, .nrst, .ce_n, .rd_n, .wr_n, .chan_sel, .dc_sel,
        .interrupt_ack_n, .chain_enable_in, .data_in, .data_out, .data_oe_n, .int_n,
        .chain_enable_out, .acc_wr, .acc_rd, .acc_chan_a, .acc_shared, .acc_alt,
        .acc_wreg_read, .acc_index, .acc_wdata, .acc_rdata, .pend_src, .ius_clear,
        .vector_in, .in_service, .pending, .fifo_en_a, .fifo_en_b, .enh_en_a, .enh_en_b);
    schp_host_model u_host (.clk, .ce_n, .rd_n, .wr_n, .chan_sel, .dc_sel,
        .interrupt_ack_n, .data_in);
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH t=%0t %s", $time, what);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        check(data_oe_n === 1'b1 && int_n === 1'b1 && fifo_en_a === 1'b0, "reset");
        check(data_out === DATA_RST, "read data after reset");
        foreach (rows[i]) begin
            u_host.access(1'b1, rows[i][15], rows[i][14], rows[i][13], rows[i][11:4]);
            check(n_acc == i + 1 && last_idx === rows[i][3:0] && last_ch === rows[i][14],
                "register index");
            if (rows[i][15]) begin
                check(last_wd === rows[i][11:4] && last_alt === rows[i][12], "wdata");
                check(last_sh === (rows[i][3:0] inside {4'h2, 4'h9}), "shared copy");
            end else begin
                check(data_out === {rows[i][14], 3'h0, rows[i][3:0]}, "read data");
                check(last_wr === rows[i][12], "write image read");
            end
        end
        check({fifo_en_a, fifo_en_b, enh_en_a, enh_en_b} === 4'h9, "enables");
        $display("test register map done");
        n0 = n_acc;
        u_host.access(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
        check(n_acc == n0, "strobe without chip enable");
        u_host.access(1'b1, 1'b1, 1'b0, 1'b0, 8'h05);
        @(posedge clk) #1 nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        n0 = n_acc;
        u_host.access(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
        check(n_acc == n0 + 1 && last_idx === IDX_CMD && fifo_en_a === 1'b0, "pointer after reset");
        $display("test reset done");
        @(posedge clk) #1 pend_src = 6'h04;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) #1 chain_enable_in = k[0];
            n0 = 0;
            while (int_n !== 1'b0 && n0 < 20) begin
                @(posedge clk) #1;
                n0++;
            end
            check(int_n === 1'b0, "request raised");
            if (int_n !== 1'b0) break;
            repeat (3) @(posedge clk);
            #1;
            check(chain_enable_out === k[0], "chain enable out");
            n0 = n_acc;
            u_host.ack_cycle();
            check(n_acc == n0, "acknowledge ignores strobes");
            check(in_service === (k ? 6'h04 : 6'h00), "in service");
            check(int_n === (k != 0) && data_out === (k ? vector_in : DATA_RST), "vector");
            check(chain_enable_out === 1'b0, "chain held");
        end
        @(posedge clk) #1 ius_clear = 1'b1;
        @(posedge clk) #1 ius_clear = 1'b0;
        check(in_service === 6'h00 && int_n === 1'b0, "service ended");
        check(chain_enable_out === 1'b1, "chain reopened");
        u_host.access(1'b1, 1'b1, 1'b1, 1'b0, 8'h02);
        @(posedge clk) #1 pend_src = 6'h01;
        repeat (6) @(posedge clk);
        #1;
        check(pending === 6'h04, "pending frozen on pointer 2");
        u_host.access(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        check(pending === 6'h01, "pending resumed");
        $display("test acknowledge done");
        complete_run();
    end
endmodule

/* File: tb/schp_hp_sva.sv */
`timescale 1ns/10ps
module schp_hp_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic interrupt_ack_n,
    input wire logic chain_enable_in,
    input wire logic data_oe_n,
    input wire logic int_n,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic acc_alt,
    input wire logic [schp_pkg::IDX_W-1:0] acc_index,
    input wire logic [schp_pkg::IP_W-1:0] in_service,
    input wire logic [schp_pkg::IP_W-1:0] pending
);
    import schp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_oe_cause: assert property (!data_oe_n |-> $past(!rd_n, 2))
        else $error("data bus driven without read strobe");
    chk_oe_drive: assert property ((!ce_n && !rd_n && interrupt_ack_n)[*4] |-> !data_oe_n)
        else $error("data bus not driven during read");
    chk_oe_idle: assert property ((ce_n && interrupt_ack_n)[*4] |-> data_oe_n)
        else $error("data bus driven without chip enable");
    chk_wr_cause: assert property (acc_wr |-> $past(!wr_n && !ce_n && interrupt_ack_n, 2))
        else $error("write access without valid strobe");
    chk_rd_cause: assert property (acc_rd |-> $past(!rd_n && !ce_n && interrupt_ack_n, 2))
        else $error("read access without valid strobe");
    chk_one_access: assert property ((acc_wr || acc_rd) |=> !(acc_wr || acc_rd))
        else $error("access pulse longer than one cycle");
    chk_alt_index: assert property (acc_alt |-> acc_wr && acc_index == 4'h7)
        else $error("alternate write not on register seven");
    chk_ius_chain: assert property ($rose(|in_service) |-> !interrupt_ack_n && chain_enable_in)
        else $error("in service set outside granted acknowledge");
    chk_int_drop: assert property ($rose(|in_service) |-> int_n)
        else $error("request not dropped when in service set");
    chk_pend_half: assert property ($changed(pending) |=> $stable(pending))
        else $error("pending bits updated at full rate");
    cover property (acc_alt);
    cover property ($rose(|in_service));
    cover property (acc_rd && acc_index == 4'h8);
endmodule
bind schp_host_port schp_hp_sva u_sva (.clk, .nrst, .ce_n, .rd_n, .wr_n, .interrupt_ack_n,
    .chain_enable_in, .data_oe_n, .int_n, .acc_wr, .acc_rd, .acc_alt, .acc_index,
    .in_service, .pending);
